// *** src/edge_line_event_unit.sv ***
// edge line event unit: apb registers, pending bits and request outputs
//
// Operation
// RL1: nineteen edge lines raise interrupt or event
// RL2: per-line rising, falling or both edges
// RL3: independent mask per line, no cross effects
// RL4: pending bit set on edge, readable
// RL5: catch pulses shorter than bus clock period
// RL6: sixteen lines selected from eighty pins
// RL7: extra lines: supply monitor, rtc, usb wakeup
// RL8: any line wakes from stop, clockless
// RL9: pending cleared only by writing one
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module edge_line_event_unit
    import edge_line_event_pkg::*;
(
    // clock and reset
    input  wire logic                  MCLK_I,
    input  wire logic                  RST_I,
    // apb slave
    input  wire edge_line_event_pkg::apb_req_t APB_REQ_I,
    output logic [31:0]                PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    // line sources
    input  wire logic [NUM_PINS-1:0]   GPIO_PIN_I,
    input  wire logic                  SUPPLY_MON_I,
    input  wire logic                  RTC_ALARM_I,
    input  wire logic                  USB_WAKE_I,
    // requests
    output logic                       IRQ_O,
    output logic [NUM_LINES-1:0]       IRQ_LINE_O,
    output logic [NUM_LINES-1:0]       EVT_O,
    output logic                       WAKE_O
);

    import edge_line_event_pkg::*;

    // configuration state
    logic [NUM_LINES-1:0] irq_mask;       // 1 lets the line interrupt
    logic [NUM_LINES-1:0] evt_mask;       // 1 lets the line send events
    logic [NUM_LINES-1:0] rise_en;        // rising edge trigger
    logic [NUM_LINES-1:0] fall_en;        // falling edge trigger
    logic [31:0]          sel_lo;         // port select, lines 0..7
    logic [31:0]          sel_hi;         // port select, lines 8..15
    logic [NUM_LINES-1:0] next_irq_mask;
    logic [NUM_LINES-1:0] next_evt_mask;
    logic [NUM_LINES-1:0] next_rise_en;
    logic [NUM_LINES-1:0] next_fall_en;
    logic [31:0]          next_sel_lo;
    logic [31:0]          next_sel_hi;

    // pending state
    logic [NUM_LINES-1:0] pend;           // sticky edge status
    logic [NUM_LINES-1:0] next_pend;

    // output state
    logic [31:0]          rdata;          // read data, set in setup
    logic [31:0]          next_rdata;
    logic [NUM_LINES-1:0] irq_line;
    logic [NUM_LINES-1:0] next_irq_line;
    logic [NUM_LINES-1:0] evt;
    logic [NUM_LINES-1:0] next_evt;

    // line fabric
    logic [NUM_PIN_LINES-1:0][SEL_W-1:0] sel_field;
    logic [NUM_PIN_LINES-1:0] pin_line;   // after port selection
    logic [NUM_LINES-1:0] line_in;        // all line sources
    logic [NUM_LINES-1:0] hit;            // one pulse per edge
    logic [NUM_LINES-1:0] armed;          // async captured flags
    logic [NUM_LINES-1:0] level;          // synced line levels

    // bus decode
    logic                 setup_ph;
    logic                 wr_acc;
    logic                 mapped;

    // access phase write; setup phase prepares read data
    assign setup_ph = APB_REQ_I.psel & ~APB_REQ_I.penable;
    assign wr_acc   = APB_REQ_I.psel & APB_REQ_I.penable
                      & APB_REQ_I.pwrite;

    // address decode, only the eight words answer
    always_comb begin
        case (APB_REQ_I.paddr)
            OFF_IRQ_MASK: mapped = 1'b1;
            OFF_EVT_MASK: mapped = 1'b1;
            OFF_RISE:     mapped = 1'b1;
            OFF_FALL:     mapped = 1'b1;
            OFF_PEND:     mapped = 1'b1;
            OFF_SEL_LO:   mapped = 1'b1;
            OFF_SEL_HI:   mapped = 1'b1;
            OFF_LEVEL:    mapped = 1'b1;
            default:      mapped = 1'b0;
        endcase
    end

    // zero wait states; unmapped words report an error
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = APB_REQ_I.psel & APB_REQ_I.penable & ~mapped;

    // unpack the select words into per-line fields
    genvar gs;
    generate
        for (gs = 0; gs < NUM_PIN_LINES; gs++) begin : g_field
            if (gs < 8) begin : g_lo
                assign sel_field[gs] = sel_lo[gs*SEL_W +: SEL_W];
            end else begin : g_hi
                assign sel_field[gs] = sel_hi[(gs-8)*SEL_W +: SEL_W];
            end
        end
    endgenerate

    // pin routing onto the sixteen pin lines
    pin_line_select u_sel (
        .pins_i  (GPIO_PIN_I),
        .sel_i   (sel_field),
        .lines_o (pin_line)
    );

    // internal sources occupy the top three lines
    always_comb begin  // RL7
        line_in                   = '0;
        line_in[NUM_PIN_LINES-1:0] = pin_line;
        line_in[LINE_SUPPLY]      = SUPPLY_MON_I;
        line_in[LINE_RTC]         = RTC_ALARM_I;
        line_in[LINE_USB]         = USB_WAKE_I;
    end

    // one detector per line, each with its own trigger choice
    genvar gl;
    generate
        for (gl = 0; gl < NUM_LINES; gl++) begin : g_line  // RL1
            edge_catch u_edge (
                .clk_i     (MCLK_I),
                .rst_i     (RST_I),
                .line_i    (line_in[gl]),
                .rise_en_i (rise_en[gl]),
                .fall_en_i (fall_en[gl]),
                .hit_o     (hit[gl]),
                .armed_o   (armed[gl]),
                .lvl_o     (level[gl])
            );
        end
    endgenerate

    // configuration next values from bus writes
    always_comb begin
        next_irq_mask = irq_mask;
        next_evt_mask = evt_mask;
        next_rise_en  = rise_en;
        next_fall_en  = fall_en;
        next_sel_lo   = sel_lo;
        next_sel_hi   = sel_hi;
        if (wr_acc) begin
            case (APB_REQ_I.paddr)
                OFF_IRQ_MASK: begin  // RL3
                    next_irq_mask = APB_REQ_I.pwdata[NUM_LINES-1:0];
                end
                OFF_EVT_MASK: begin  // RL3
                    next_evt_mask = APB_REQ_I.pwdata[NUM_LINES-1:0];
                end
                OFF_RISE: begin  // RL2
                    next_rise_en = APB_REQ_I.pwdata[NUM_LINES-1:0];
                end
                OFF_FALL: begin  // RL2
                    next_fall_en = APB_REQ_I.pwdata[NUM_LINES-1:0];
                end
                OFF_SEL_LO: begin  // RL6
                    next_sel_lo = APB_REQ_I.pwdata;
                end
                OFF_SEL_HI: begin  // RL6
                    next_sel_hi = APB_REQ_I.pwdata;
                end
                default: begin
                    // pending, level and holes: no config change
                end
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_mask <= RST_MASK;
            evt_mask <= RST_MASK;
            rise_en  <= RST_TRIG;
            fall_en  <= RST_TRIG;
            sel_lo   <= RST_SEL;
            sel_hi   <= RST_SEL;
        end else begin
            irq_mask <= next_irq_mask;
            evt_mask <= next_evt_mask;
            rise_en  <= next_rise_en;
            fall_en  <= next_fall_en;
            sel_lo   <= next_sel_lo;
            sel_hi   <= next_sel_hi;
        end
    end

    // pending: write one clears, new edge wins over the clear
    always_comb begin
        next_pend = pend;
        if (wr_acc && APB_REQ_I.paddr == OFF_PEND) begin
            next_pend = pend & ~APB_REQ_I.pwdata[NUM_LINES-1:0];  // RL9
        end
        next_pend = next_pend | hit;  // RL4
    end

    // pending register
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            pend <= '0;
        end else begin
            pend <= next_pend;
        end
    end

    // outputs and read data next values
    always_comb begin
        // interrupts follow pending bits gated per line
        next_irq_line = next_pend & next_irq_mask;  // RL3
        // events are single pulses, no pending needed
        next_evt      = hit & evt_mask;  // RL1
        next_rdata    = 32'h00000000;
        if (setup_ph && !APB_REQ_I.pwrite) begin
            case (APB_REQ_I.paddr)
                OFF_IRQ_MASK: next_rdata = {13'h0000, irq_mask};
                OFF_EVT_MASK: next_rdata = {13'h0000, evt_mask};
                OFF_RISE:     next_rdata = {13'h0000, rise_en};
                OFF_FALL:     next_rdata = {13'h0000, fall_en};
                OFF_PEND:     next_rdata = {13'h0000, next_pend};  // RL4
                OFF_SEL_LO:   next_rdata = sel_lo;
                OFF_SEL_HI:   next_rdata = sel_hi;
                OFF_LEVEL:    next_rdata = {13'h0000, level};
                default:      next_rdata = 32'h00000000;
            endcase
        end else begin
            // hold through the access phase
            next_rdata = rdata;
        end
    end

    // output registers
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata    <= 32'h00000000;
            irq_line <= '0;
            evt      <= '0;
        end else begin
            rdata    <= next_rdata;
            irq_line <= next_irq_line;
            evt      <= next_evt;
        end
    end

    // drive ports
    assign PRDATA_O   = rdata;
    assign IRQ_LINE_O = irq_line;
    assign EVT_O      = evt;
    assign IRQ_O      = |irq_line;

    // wake straight from the async flags, no clock in the path
    // trade-off: this level is not glitch-free, meant for power control
    assign WAKE_O = |(armed & (irq_mask | evt_mask));  // RL8

endmodule : edge_line_event_unit

// *** src/edge_line_event_pkg.sv ***
// shared constants, register map and bus carrier for the edge line unit
package edge_line_event_pkg;

    // line counts
    localparam int NUM_LINES     = 19;  // all edge detector lines
    localparam int NUM_PIN_LINES = 16;  // lines fed from pins
    localparam int NUM_PORTS     = 5;   // pin groups of sixteen
    localparam int NUM_PINS      = 80;  // selectable pins
    localparam int SEL_W         = 4;   // per-line port select field

    // internal source line positions
    localparam int LINE_SUPPLY = 16;  // supply_threshold_monitor output
    localparam int LINE_RTC    = 17;  // real-time clock alarm
    localparam int LINE_USB    = 18;  // usb wakeup indication

    // register byte offsets
    localparam logic [7:0] OFF_IRQ_MASK = 8'h00;  // interrupt enables
    localparam logic [7:0] OFF_EVT_MASK = 8'h04;  // event enables
    localparam logic [7:0] OFF_RISE     = 8'h08;  // rising trigger
    localparam logic [7:0] OFF_FALL     = 8'h0c;  // falling trigger
    localparam logic [7:0] OFF_PEND     = 8'h10;  // pending, w1c
    localparam logic [7:0] OFF_SEL_LO   = 8'h14;  // port select 0..7
    localparam logic [7:0] OFF_SEL_HI   = 8'h18;  // port select 8..15
    localparam logic [7:0] OFF_LEVEL    = 8'h1c;  // synced line levels

    // reset values
    localparam logic [18:0] RST_MASK = 19'h00000;  // all lines masked
    localparam logic [18:0] RST_TRIG = 19'h00000;  // no trigger
    localparam logic [31:0] RST_SEL  = 32'h00000000;  // port 0

    // apb request as one bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage : edge_line_event_pkg

// *** src/edge_catch.sv ***
// one edge detector line: clockless capture plus clock-domain handshake
`timescale 1ns/100ps
module edge_catch (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // line and trigger selection
    input  wire logic line_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    // results
    output logic      hit_o,
    output logic      armed_o,
    output logic      lvl_o
);

    logic       rise_cap;  // set by the line itself, no clock needed
    logic       fall_cap;  // same for the falling edge
    logic [2:0] rise_s;    // synchroniser plus edge history
    logic [2:0] fall_s;
    logic [1:0] lvl_s;     // plain level synchroniser
    logic       rise_clr;
    logic       fall_clr;

    // clear once seen in the clock domain, or while disabled
    // hazard: an edge inside the clear window is merged with the last
    assign rise_clr = rst_i | ~rise_en_i | rise_s[1];  // RL2
    assign fall_clr = rst_i | ~fall_en_i | fall_s[1];  // RL2

    // the pin clocks the flag so sub-period pulses are kept
    always_ff @(posedge line_i or posedge rise_clr) begin  // RL5
        if (rise_clr) begin
            rise_cap <= 1'b0;
        end else begin
            rise_cap <= 1'b1;
        end
    end

    // falling edge flag, same scheme on the other edge
    always_ff @(negedge line_i or posedge fall_clr) begin  // RL5
        if (fall_clr) begin
            fall_cap <= 1'b0;
        end else begin
            fall_cap <= 1'b1;
        end
    end

    // bring flags and level into the bus clock
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rise_s <= 3'h0;
            fall_s <= 3'h0;
            lvl_s  <= 2'h0;
        end else begin
            rise_s <= {rise_s[1:0], rise_cap};
            fall_s <= {fall_s[1:0], fall_cap};
            lvl_s  <= {lvl_s[0], line_i};
        end
    end

    // one pulse per captured edge
    assign hit_o   = (rise_s[1] & ~rise_s[2]) | (fall_s[1] & ~fall_s[2]);
    // async view for wakeup while the clock is halted
    assign armed_o = rise_cap | fall_cap;  // RL8
    assign lvl_o   = lvl_s[1];

endmodule : edge_catch

// *** src/pin_line_select.sv ***
// routes one of five pin groups onto each of the sixteen pin lines
`timescale 1ns/100ps
module pin_line_select
    import edge_line_event_pkg::*;
(
    // pins and selection
    input  wire logic [NUM_PINS-1:0]             pins_i,
    input  wire logic [NUM_PIN_LINES-1:0][SEL_W-1:0] sel_i,
    // selected lines
    output logic [NUM_PIN_LINES-1:0]             lines_o
);

    // line i picks pin i of the chosen group; out of range picks group 0
    // limitation: changing a select can itself look like an edge
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PIN_LINES; gi++) begin : g_sel
            always_comb begin  // RL6
                lines_o[gi] = pins_i[gi];
                for (int p = 1; p < NUM_PORTS; p++) begin
                    if (sel_i[gi] == SEL_W'(p)) begin
                        lines_o[gi] = pins_i[p*NUM_PIN_LINES+gi];
                    end
                end
            end
        end
    endgenerate

endmodule : pin_line_select

// *** testbench/edge_line_event_chk.sv ***
// concurrent checks on the edge line unit ports
`timescale 1ns/100ps
module edge_line_event_chk
    import edge_line_event_pkg::*;
(
    // clock and reset
    input  wire logic                         MCLK_I,
    input  wire logic                         RST_I,
    // apb side
    input  wire edge_line_event_pkg::apb_req_t APB_REQ_I,
    input  wire logic [31:0]                  PRDATA_O,
    input  wire logic                         PREADY_O,
    input  wire logic                         PSLVERR_O,
    // requests
    input  wire logic                         IRQ_O,
    input  wire logic [NUM_LINES-1:0]         IRQ_LINE_O,
    input  wire logic [NUM_LINES-1:0]         EVT_O
);
    wire logic  acc = APB_REQ_I.psel & APB_REQ_I.penable; // access phase
    wire logic  clr = acc & APB_REQ_I.pwrite &
        (APB_REQ_I.paddr == OFF_PEND | APB_REQ_I.paddr == OFF_IRQ_MASK);
    logic [2:0] recent;      // cycles left since a clear or mask write
    logic [2:0] next_recent; // next value
    // irq may only drop shortly after software touched it
    always_comb begin
        next_recent = clr ? 3'h4 : (recent != 3'h0 ? recent - 3'h1 : 3'h0);
    end
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I)
            recent <= 3'h0;
        else
            recent <= next_recent;
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    // read access in progress
    sequence rd_s;
        acc && !APB_REQ_I.pwrite;
    endsequence
    ready_a: assert property (PREADY_O)
        else $error("pready dropped");
    irq_or_a: assert property (IRQ_O == (|IRQ_LINE_O))
        else $error("irq not the or of line requests");
    evt_once_a: assert property (EVT_O[0] |=> !EVT_O[0] [*3])
        else $error("event pulse repeated");
    err_phase_a: assert property (PSLVERR_O == (acc &&
        (APB_REQ_I.paddr[1:0] != 2'h0 || APB_REQ_I.paddr > OFF_LEVEL)))
        else $error("slave error on wrong access");
    unmapped_a: assert property (rd_s ##0 APB_REQ_I.paddr > 8'h1c
        |-> PSLVERR_O && PRDATA_O == 32'h0)
        else $error("unmapped read not refused");
    hi_zero_a: assert property (rd_s ##0 (APB_REQ_I.paddr != OFF_SEL_LO
        && APB_REQ_I.paddr != OFF_SEL_HI) |-> PRDATA_O[31:19] == 13'h0)
        else $error("upper read bits set");
    pend_read_a: assert property (rd_s ##0 APB_REQ_I.paddr == OFF_PEND
        |-> (PRDATA_O[18:0] & IRQ_LINE_O) == IRQ_LINE_O)
        else $error("pending read misses a request");
    clear_cause_a: assert property ($fell(IRQ_O) |-> recent != 3'h0)
        else $error("irq dropped without a write");
endmodule : edge_line_event_chk
bind edge_line_event_unit edge_line_event_chk edge_line_event_chk_i (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .APB_REQ_I(APB_REQ_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .IRQ_O(IRQ_O), .IRQ_LINE_O(IRQ_LINE_O), .EVT_O(EVT_O));

// *** testbench/line_source.sv ***
// pin and internal source model driving the line inputs
`timescale 1ns/100ps
module line_source
    import edge_line_event_pkg::*;
(
    // pin side
    output logic [NUM_PINS-1:0] gpio_o,
    // internal sources
    output logic                supply_o,
    output logic                rtc_o,
    output logic                usb_o
);
    logic [NUM_PINS+2:0] lvl = '0; // all source levels, pins first
    assign gpio_o   = lvl[NUM_PINS-1:0];
    assign supply_o = lvl[NUM_PINS];
    assign rtc_o    = lvl[NUM_PINS+1];
    assign usb_o    = lvl[NUM_PINS+2];
    // pin lines sit in group pg, internal lines follow the pins
    task automatic set(input int ln, input int pg, input logic v);
        lvl[ln < 16 ? pg * 16 + ln : NUM_PINS + ln - 16] = v;
    endtask : set
    // pulse far narrower than one bus clock period
    task automatic pulse(input int ln, input int pg);
        set(ln, pg, 1'b1);
        #2;
        set(ln, pg, 1'b0);
    endtask : pulse
endmodule : line_source

// *** testbench/edge_line_event_unit_test.sv ***
// self-checking bench for the edge line event unit
`timescale 1ns/100ps
module edge_line_event_unit_test;
    import edge_line_event_pkg::*;
    // line, select, driven group, rise, fall, stimulus kind, hit
    typedef struct {
        int   ln;   // line number
        int   sel;  // select field value
        int   pg;   // group the source drives
        logic r;    // rising trigger
        logic f;    // falling trigger
        int   kind; // 0 step up, 1 step down, 2 narrow pulse
        logic hit;  // pending expected
    } row_t;
    row_t rows[11] = '{'{0,0,0,1,0,0,1}, '{3,1,1,0,1,0,0},
        '{7,2,2,0,1,1,1}, '{9,3,3,1,0,1,0}, '{12,4,4,1,1,2,1},
        '{15,5,0,1,0,2,1}, '{5,1,2,1,1,2,0}, '{16,0,0,0,1,1,1},
        '{17,0,0,1,0,2,1}, '{18,0,0,1,1,0,1}, '{10,0,0,0,0,2,0}};
    logic                 mclk = 1'b0; // bus clock
    logic                 rst  = 1'b1; // async reset
    apb_req_t             req  = '0;   // apb request bundle
    logic [31:0]          prdata, q;   // read data, last taken
    logic                 pready, pslverr, e, irq, wake;
    logic [NUM_PINS-1:0]  gpio;        // pin levels
    logic                 supply, rtc, usb;
    logic [NUM_LINES-1:0] irq_line, evt;
    int                   bad_count = 0;
    int                   checked = 0;
    initial begin
        forever #5 mclk = ~mclk;
    end
    edge_line_event_unit edge_line_event_unit_i (.MCLK_I(mclk), .RST_I(rst),
        .APB_REQ_I(req), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .GPIO_PIN_I(gpio), .SUPPLY_MON_I(supply),
        .RTC_ALARM_I(rtc), .USB_WAKE_I(usb), .IRQ_O(irq),
        .IRQ_LINE_O(irq_line), .EVT_O(evt), .WAKE_O(wake));
    line_source line_source_i (.gpio_o(gpio), .supply_o(supply),
        .rtc_o(rtc), .usb_o(usb));
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] got);
        checked++;
        if (got !== x) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, got);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    // one transfer, held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            bad_count++;
            test_done();
        end else begin
            q = prdata;
            e = pslverr;
            req <= '0;
        end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask : rd
    initial begin
        int ev;
        logic [NUM_LINES-1:0] evs;  // lines that sent an event
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b1, OFF_IRQ_MASK, 32'h7ffff);
        apb(1'b1, OFF_EVT_MASK, 32'h7ffff);
        foreach (rows[i]) begin
            line_source_i.set(rows[i].ln, rows[i].pg, rows[i].kind == 1);
            apb(1'b1, OFF_SEL_LO + 8'(rows[i].ln / 8 * 4),
                32'(rows[i].sel) << (4 * (rows[i].ln % 8)));
            apb(1'b1, OFF_RISE, 32'(rows[i].r) << rows[i].ln);
            apb(1'b1, OFF_FALL, 32'(rows[i].f) << rows[i].ln);
            apb(1'b1, OFF_PEND, 32'h7ffff);
            @(negedge mclk);
            if (rows[i].kind == 2)
                line_source_i.pulse(rows[i].ln, rows[i].pg);
            else
                line_source_i.set(rows[i].ln, rows[i].pg, rows[i].kind == 0);
            #1;
            if (rows[i].hit)
                chk("wake", 32'h1, 32'(wake));
            ev = 0;
            repeat (8) begin
                @(posedge mclk);
                #1 ev += 32'(evt[rows[i].ln]);
            end
            chk("events", 32'(rows[i].hit), 32'(ev));
            rd(OFF_PEND, 32'(rows[i].hit) << rows[i].ln, "pending");
            chk("irq", 32'(rows[i].hit), 32'(irq));
            apb(1'b1, OFF_RISE, 32'h0);
            apb(1'b1, OFF_FALL, 32'h0);
            line_source_i.set(rows[i].ln, rows[i].pg, 1'b0);
            apb(1'b1, OFF_PEND, 32'h0);
            rd(OFF_PEND, 32'(rows[i].hit) << rows[i].ln, "kept");
            apb(1'b1, OFF_PEND, 32'h1 << rows[i].ln);
            rd(OFF_PEND, 32'h0, "cleared");
        end
        // two lines pending, one unmasked for events, the other for irq
        apb(1'b1, OFF_IRQ_MASK, 32'h20000);
        apb(1'b1, OFF_EVT_MASK, 32'h10000);
        apb(1'b1, OFF_RISE, 32'h30000);
        @(negedge mclk);
        line_source_i.pulse(LINE_SUPPLY, 0);
        line_source_i.pulse(LINE_RTC, 0);
        evs = '0;
        repeat (8) begin
            @(posedge mclk);
            #1 evs |= evt;
        end
        chk("event lines", 32'h10000, 32'(evs));
        chk("irq lines", 32'h20000, 32'(irq_line));
        rd(OFF_PEND, 32'h30000, "both pending");
        apb(1'b0, 8'h20, 32'h0);
        chk("slave error", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, q);
        // level view follows a held line after two sync stages
        line_source_i.set(LINE_USB, 0, 1'b1);
        repeat (2) @(posedge mclk);
        rd(OFF_LEVEL, 32'h40000, "level");
        line_source_i.set(LINE_USB, 0, 1'b0);
        // reset in mid-run wipes pending and masks
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk("irq after reset", 32'h0, 32'(irq));
        for (int a = 0; a < 32; a += 4)
            rd(8'(a), 32'h0, "reset value");
        test_done();
    end
endmodule : edge_line_event_unit_test
